// ### src/dtrig_top.sv
// trigger match logic and debug control/status csrs of a machine-mode hart
// assumes: csr port driven by the hart's csr unit, hart events one cycle each
//
// Contract
// [RULE1] kind 0: exact equality match
// [RULE2] kind 1: compare top M bits only
// [RULE3] other kind encodings are reserved
// [RULE4] machine-mode enable bit gates trigger
// [RULE5] supervisor/user enables read as zero
// [RULE6] execute enable fires on instruction address
// [RULE7] store enable fires on address or data
// [RULE8] load enable fires on address only
// [RULE9] compare value: 32-bit read/write, resets zero
// [RULE10] compare value decoded at 0x7A2
// [RULE11] debug csr outside debug mode: illegal
// [RULE12] debug version field reads four
// [RULE13] ebreak enable sends ebreak to debug
// [RULE14] step interrupt enable bit
// [RULE15] debugger changes step enable only halted
// [RULE16] hit flag set on match, software writable
// [RULE17] select bit: address or store data
// [RULE18] action: breakpoint or enter debug
// [RULE19] unsupported kind writes are ignored
// [RULE20] reserved bits read zero, ignore writes
`timescale 1ns/10ps
`default_nettype none
`include "dtrig_defines.svh"
module dtrig_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // csr access from the hart
  input wire logic csr_req_i,
  input wire logic csr_we_i,
  input wire logic [11:0] csr_addr_i,
  input wire dtrig_pkg::dtrig_word_t csr_wdata_i,
  output logic csr_ack_o,
  output logic csr_illegal_o,
  output dtrig_pkg::dtrig_word_t csr_rdata_o,
  // hart state
  input wire logic dbg_mode_i,
  input wire logic mmode_i,
  // observed hart traffic
  input wire logic exec_vld_i,
  input wire dtrig_pkg::dtrig_word_t exec_addr_i,
  input wire logic ld_vld_i,
  input wire dtrig_pkg::dtrig_word_t ld_addr_i,
  input wire logic st_vld_i,
  input wire dtrig_pkg::dtrig_word_t st_addr_i,
  input wire dtrig_pkg::dtrig_word_t st_data_i,
  input wire logic ebreak_i,
  // results to the hart
  output logic trig_bkpt_o,
  output logic trig_dbg_o,
  output logic ebreak_dbg_o,
  output logic ebreak_trap_o,
  output logic step_ie_o
);

  // ****************************************
  // state
  // ****************************************
  dtrig_pkg::dtrig_word_t cmp_q;
  dtrig_pkg::dtrig_kind_e kind_q;
  dtrig_pkg::dtrig_act_e act_q;
  logic hit_q;
  logic sel_q;
  logic men_q;
  logic exe_q;
  logic ste_q;
  logic lde_q;
  logic ebm_q;

  // ****************************************
  // csr decode
  // ****************************************
  logic sel_ctrl;
  logic sel_cmp;
  logic sel_dbgcs;
  logic acc_ok;
  logic wr_ctrl;
  logic wr_cmp;
  logic wr_dbgcs;
  dtrig_pkg::dtrig_word_t ctrl_view;
  dtrig_pkg::dtrig_word_t dbgcs_view;
  dtrig_pkg::dtrig_word_t rdata_d;
  logic [3:0] wr_kind;
  logic [3:0] wr_act;

  always_comb begin
    sel_ctrl = 1'b0;
    sel_cmp = 1'b0;
    sel_dbgcs = 1'b0;
    if (csr_addr_i == `DTRIG_CSR_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (csr_addr_i == `DTRIG_CSR_CMP) begin
      sel_cmp = 1'b1; // [RULE10]
    end else if (csr_addr_i == `DTRIG_CSR_DBGCS) begin
      sel_dbgcs = 1'b1;
    end
  end

  // debug csr needs debug mode; unmapped addresses are illegal as well
  assign acc_ok = sel_ctrl || sel_cmp || (sel_dbgcs && dbg_mode_i); // [RULE11]
  assign wr_ctrl = csr_req_i && csr_we_i && sel_ctrl;
  assign wr_cmp = csr_req_i && csr_we_i && sel_cmp;
  assign wr_dbgcs = csr_req_i && csr_we_i && sel_dbgcs && dbg_mode_i; // [RULE11]
  assign wr_kind = csr_wdata_i[`DTRIG_KIND_HI:`DTRIG_KIND_LO];
  assign wr_act = csr_wdata_i[`DTRIG_ACT_HI:`DTRIG_ACT_LO];

  // supervisor/user enables and all reserved bits are tied to zero here
  always_comb begin
    ctrl_view = 32'h0000_0000; // [RULE5] [RULE20]
    ctrl_view[`DTRIG_HIT] = hit_q;
    ctrl_view[`DTRIG_SEL] = sel_q;
    ctrl_view[`DTRIG_ACT_HI:`DTRIG_ACT_LO] = {3'h0, act_q};
    ctrl_view[`DTRIG_KIND_HI:`DTRIG_KIND_LO] = {3'h0, kind_q};
    ctrl_view[`DTRIG_MEN] = men_q;
    ctrl_view[`DTRIG_EXE] = exe_q;
    ctrl_view[`DTRIG_STE] = ste_q;
    ctrl_view[`DTRIG_LDE] = lde_q;
  end

  always_comb begin
    dbgcs_view = 32'h0000_0000; // [RULE5] [RULE20]
    dbgcs_view[`DTRIG_VER_HI:`DTRIG_VER_LO] = `DTRIG_VER_VAL; // [RULE12]
    dbgcs_view[`DTRIG_EBM] = ebm_q;
    dbgcs_view[`DTRIG_STEPIE] = step_ie_o;
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (!acc_ok) begin
      rdata_d = 32'h0000_0000;
    end else if (sel_ctrl) begin
      rdata_d = ctrl_view;
    end else if (sel_cmp) begin
      rdata_d = cmp_q;
    end else if (sel_dbgcs) begin
      rdata_d = dbgcs_view;
    end
  end

  // ****************************************
  // csr answer
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      csr_ack_o <= 1'b0;
      csr_illegal_o <= 1'b0;
      csr_rdata_o <= 32'h0000_0000;
    end else begin
      csr_ack_o <= csr_req_i;
      csr_illegal_o <= csr_req_i && !acc_ok; // [RULE11]
      csr_rdata_o <= csr_req_i ? rdata_d : 32'h0000_0000;
    end
  end

  // ****************************************
  // trigger control register
  // ****************************************
  logic fire;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sel_q <= `DTRIG_BIT_RST;
      men_q <= `DTRIG_BIT_RST;
      exe_q <= `DTRIG_BIT_RST;
      ste_q <= `DTRIG_BIT_RST;
      lde_q <= `DTRIG_BIT_RST;
    end else if (wr_ctrl) begin
      sel_q <= csr_wdata_i[`DTRIG_SEL]; // [RULE17]
      men_q <= csr_wdata_i[`DTRIG_MEN]; // [RULE4]
      exe_q <= csr_wdata_i[`DTRIG_EXE]; // [RULE6]
      ste_q <= csr_wdata_i[`DTRIG_STE]; // [RULE7]
      lde_q <= csr_wdata_i[`DTRIG_LDE]; // [RULE8]
    end
  end

  // reserved encodings leave the field as it was
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      kind_q <= dtrig_pkg::DTRIG_KIND_EQ;
      act_q <= dtrig_pkg::DTRIG_ACT_BKPT;
    end else if (wr_ctrl) begin
      if (wr_kind == `DTRIG_F4_EQ) begin
        kind_q <= dtrig_pkg::DTRIG_KIND_EQ; // [RULE19]
      end else if (wr_kind == `DTRIG_F4_ONE) begin
        kind_q <= dtrig_pkg::DTRIG_KIND_TOP; // [RULE3] [RULE19]
      end
      if (wr_act == `DTRIG_F4_EQ) begin
        act_q <= dtrig_pkg::DTRIG_ACT_BKPT;
      end else if (wr_act == `DTRIG_F4_ONE) begin
        act_q <= dtrig_pkg::DTRIG_ACT_DBG;
      end
    end
  end

  // a match in the same cycle as a clearing write still leaves the flag set
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hit_q <= `DTRIG_BIT_RST;
    end else if (fire) begin
      hit_q <= 1'b1; // [RULE16]
    end else if (wr_ctrl) begin
      hit_q <= csr_wdata_i[`DTRIG_HIT]; // [RULE16]
    end
  end

  // ****************************************
  // compare value and debug control
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cmp_q <= `DTRIG_CMP_RST;
    end else if (wr_cmp) begin
      cmp_q <= csr_wdata_i; // [RULE9]
    end
  end

  // step enable is guarded against writes while running: wr_dbgcs only writes it in debug mode
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ebm_q <= `DTRIG_BIT_RST;
      step_ie_o <= `DTRIG_BIT_RST;
    end else if (wr_dbgcs) begin
      ebm_q <= csr_wdata_i[`DTRIG_EBM]; // [RULE13]
      step_ie_o <= csr_wdata_i[`DTRIG_STEPIE]; // [RULE14] [RULE15]
    end
  end

  // ****************************************
  // match logic
  // ****************************************
  logic hit_ex;
  logic hit_ld;
  logic hit_st;
  logic active;
  dtrig_pkg::dtrig_word_t st_val;

  assign st_val = sel_q ? st_data_i : st_addr_i; // [RULE17]

  dtrig_cmp u_cmp_ex (
    .value_i(exec_addr_i),
    .cmp_i(cmp_q),
    .kind_i(kind_q),
    .hit_o(hit_ex)
  );

  dtrig_cmp u_cmp_ld (
    .value_i(ld_addr_i),
    .cmp_i(cmp_q),
    .kind_i(kind_q),
    .hit_o(hit_ld)
  );

  dtrig_cmp u_cmp_st (
    .value_i(st_val),
    .cmp_i(cmp_q),
    .kind_i(kind_q),
    .hit_o(hit_st)
  );

  // debug mode itself never fires the trigger
  assign active = men_q && mmode_i && !dbg_mode_i; // [RULE4]
  // with select set only store data qualifies; load data is never seen
  assign fire = active && ((exec_vld_i && exe_q && !sel_q && hit_ex) // [RULE6]
    || (ld_vld_i && lde_q && !sel_q && hit_ld) // [RULE8]
    || (st_vld_i && ste_q && hit_st)); // [RULE7]

  dtrig_fire u_fire (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .fire_i(fire),
    .act_i(act_q),
    .ebreak_i(ebreak_i),
    .ebreakm_i(ebm_q),
    .bkpt_o(trig_bkpt_o),
    .dbg_o(trig_dbg_o),
    .ebreak_dbg_o(ebreak_dbg_o),
    .ebreak_trap_o(ebreak_trap_o)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_exec_exact: assert property ( // [RULE1]
    active && exec_vld_i && exe_q && !sel_q && kind_q == dtrig_pkg::DTRIG_KIND_EQ
    && exec_addr_i == cmp_q |=> trig_bkpt_o || trig_dbg_o)
    else $error("exact execute match did not fire");

  a_top_bits: assert property ( // [RULE2]
    active && ld_vld_i && lde_q && !sel_q && kind_q == dtrig_pkg::DTRIG_KIND_TOP
    && (ld_addr_i ^ cmp_q) == 32'h0000_0001 && cmp_q[0] == 1'b0 |=> trig_bkpt_o || trig_dbg_o)
    else $error("low masked bit blocked a top-bits match");

  a_men_gate: assert property ( // [RULE4]
    !men_q || !mmode_i |=> !trig_bkpt_o && !trig_dbg_o)
    else $error("trigger fired while disabled");

  a_load_data: assert property ( // [RULE8]
    sel_q && !st_vld_i |=> !trig_bkpt_o && !trig_dbg_o)
    else $error("data select fired without a store");

  a_kind_legal: assert property ( // [RULE19]
    wr_ctrl && wr_kind > 4'h1 |=> kind_q == $past(kind_q))
    else $error("compare kind took a reserved value");

  a_dbgcs_illegal: assert property ( // [RULE11]
    csr_req_i && sel_dbgcs && !dbg_mode_i |=> csr_ack_o && csr_illegal_o && csr_rdata_o == 32'h0000_0000)
    else $error("debug csr reachable outside debug mode");

  a_dbgcs_ver: assert property ( // [RULE12]
    csr_req_i && sel_dbgcs && dbg_mode_i |=> csr_rdata_o[31:28] == `DTRIG_VER_VAL && !csr_illegal_o)
    else $error("debug version field wrong");

  a_hit_sticky: assert property ( // [RULE16]
    fire |=> hit_q ##0 (trig_bkpt_o != trig_dbg_o))
    else $error("hit flag or action missing after match");

  a_ebreak_route: assert property ( // [RULE13]
    ebreak_i |=> ebreak_dbg_o == $past(ebm_q) && ebreak_trap_o == !$past(ebm_q))
    else $error("ebreak routed wrong");

  a_step_ie: assert property ( // [RULE14]
    wr_dbgcs |=> step_ie_o == $past(csr_wdata_i[`DTRIG_STEPIE]))
    else $error("step interrupt enable not written");

  c_exec_fire: cover property (exec_vld_i && fire ##1 trig_dbg_o);
  c_store_data: cover property (st_vld_i && sel_q && fire);
  c_dbgcs_denied: cover property (csr_req_i && sel_dbgcs && !dbg_mode_i);
  c_hit_clear_race: cover property (fire && wr_ctrl && !csr_wdata_i[`DTRIG_HIT]);

endmodule : dtrig_top
`default_nettype wire

// ### src/dtrig_defines.svh
// offsets, field positions and reset values of the trigger and debug csrs
// assumes: included by the design files under its bare name
`ifndef DTRIG_DEFINES_SVH
`define DTRIG_DEFINES_SVH

// ****************************************
// csr addresses
// ****************************************
`define DTRIG_CSR_CTRL 12'h7A1
`define DTRIG_CSR_CMP 12'h7A2
`define DTRIG_CSR_DBGCS 12'h7B0

// ****************************************
// trigger control fields
// ****************************************
`define DTRIG_HIT 20
`define DTRIG_SEL 19
`define DTRIG_ACT_HI 15
`define DTRIG_ACT_LO 12
`define DTRIG_KIND_HI 10
`define DTRIG_KIND_LO 7
`define DTRIG_MEN 6
`define DTRIG_EXE 2
`define DTRIG_STE 1
`define DTRIG_LDE 0
`define DTRIG_F4_EQ 4'h0
`define DTRIG_F4_ONE 4'h1

// ****************************************
// debug control/status fields
// ****************************************
`define DTRIG_VER_HI 31
`define DTRIG_VER_LO 28
`define DTRIG_VER_VAL 4'h4
`define DTRIG_EBM 15
`define DTRIG_STEPIE 11

// ****************************************
// reset values
// ****************************************
`define DTRIG_CMP_RST 32'h0000_0000
`define DTRIG_BIT_RST 1'b0

`endif

// ### src/dtrig_pkg.sv
// types shared by the trigger and debug control files
// assumes: nothing beyond the defines header
package dtrig_pkg;

  typedef logic [31:0] dtrig_word_t;

  // compare kind as held in hardware; only two kinds exist
  typedef enum logic [0:0] {
    DTRIG_KIND_EQ = 1'b0,
    DTRIG_KIND_TOP = 1'b1
  } dtrig_kind_e;

  // what a firing trigger does
  typedef enum logic [0:0] {
    DTRIG_ACT_BKPT = 1'b0,
    DTRIG_ACT_DBG = 1'b1
  } dtrig_act_e;

endpackage : dtrig_pkg

// ### src/dtrig_cmp.sv
// one value comparator of the trigger: exact or top-bits match
// assumes: purely combinational, caller registers the result
`timescale 1ns/10ps
`default_nettype none
module dtrig_cmp (
  // observed and reference values
  input wire dtrig_pkg::dtrig_word_t value_i,
  input wire dtrig_pkg::dtrig_word_t cmp_i,
  // compare kind
  input wire dtrig_pkg::dtrig_kind_e kind_i,
  // result
  output logic hit_o
);

  // ones above the lowest zero of v; lowest zero and all below drop out
  function automatic dtrig_pkg::dtrig_word_t keep_mask(input dtrig_pkg::dtrig_word_t v);
    keep_mask = ~(v ^ (v + 32'h0000_0001));
  endfunction : keep_mask

  always_comb begin
    if (kind_i == dtrig_pkg::DTRIG_KIND_TOP) begin
      hit_o = ((value_i ^ cmp_i) & keep_mask(cmp_i)) == 32'h0000_0000; // [RULE2]
    end else begin
      hit_o = value_i == cmp_i; // [RULE1]
    end
  end

endmodule : dtrig_cmp
`default_nettype wire

// ### src/dtrig_fire.sv
// registers the outcome of a trigger hit and of an ebreak
// assumes: fire_i and ebreak_i are single-cycle events from the hart
`timescale 1ns/10ps
`default_nettype none
module dtrig_fire (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // events and their steering
  input wire logic fire_i,
  input wire dtrig_pkg::dtrig_act_e act_i,
  input wire logic ebreak_i,
  input wire logic ebreakm_i,
  // results, one-cycle pulses
  output logic bkpt_o,
  output logic dbg_o,
  output logic ebreak_dbg_o,
  output logic ebreak_trap_o
);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bkpt_o <= 1'b0;
      dbg_o <= 1'b0;
    end else begin
      bkpt_o <= fire_i && (act_i == dtrig_pkg::DTRIG_ACT_BKPT); // [RULE18]
      dbg_o <= fire_i && (act_i == dtrig_pkg::DTRIG_ACT_DBG); // [RULE18]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ebreak_dbg_o <= 1'b0;
      ebreak_trap_o <= 1'b0;
    end else begin
      ebreak_dbg_o <= ebreak_i && ebreakm_i; // [RULE13]
      ebreak_trap_o <= ebreak_i && !ebreakm_i; // [RULE13]
    end
  end

endmodule : dtrig_fire
`default_nettype wire

// ### bench/dtrig_hart_model.sv
// hart-side partner: csr accesses, hart state and traffic events
// assumes: dut answers a csr request on the same edge that takes it
`timescale 1ns/10ps
`default_nettype none
module dtrig_hart_model (
  // clock
  input wire logic mclk_i,
  // csr port
  output logic csr_req_o,
  output logic csr_we_o,
  output logic [11:0] csr_addr_o,
  output dtrig_pkg::dtrig_word_t csr_wdata_o,
  input wire logic csr_ack_i,
  input wire logic csr_illegal_i,
  input wire dtrig_pkg::dtrig_word_t csr_rdata_i,
  // hart state and traffic
  output logic dbg_mode_o,
  output logic mmode_o,
  output logic exec_vld_o,
  output logic ld_vld_o,
  output logic st_vld_o,
  output logic ebreak_o,
  output dtrig_pkg::dtrig_word_t exec_addr_o,
  output dtrig_pkg::dtrig_word_t ld_addr_o,
  output dtrig_pkg::dtrig_word_t st_addr_o,
  output dtrig_pkg::dtrig_word_t st_data_o
);
  initial begin
    {csr_req_o, csr_we_o, exec_vld_o, ld_vld_o, st_vld_o, ebreak_o} = 6'h00;
    {csr_addr_o, csr_wdata_o} = 44'h0;
    {exec_addr_o, ld_addr_o, st_addr_o, st_data_o} = 128'h0;
    // starts halted so the debug csr can be set up
    dbg_mode_o = 1'b1;
    mmode_o = 1'b1;
  end

  task automatic csr(input logic we, input logic [11:0] a, input dtrig_pkg::dtrig_word_t d,
                     output dtrig_pkg::dtrig_word_t rd, output logic il, output logic ak);
    @(posedge mclk_i);
    #1;
    csr_req_o = 1'b1;
    csr_we_o = we;
    csr_addr_o = a;
    csr_wdata_o = d;
    @(posedge mclk_i);
    #1;
    ak = csr_ack_i;
    il = csr_illegal_i;
    rd = csr_rdata_i;
    csr_req_o = 1'b0;
    csr_we_o = 1'b0;
    // released bus shows junk, not the last value
    csr_addr_o = ~a;
    csr_wdata_o = ~d;
  endtask : csr

  // k: 0 execute, 1 load, 2 store, 3 ebreak
  task automatic ev(input logic [1:0] k, input dtrig_pkg::dtrig_word_t a, input dtrig_pkg::dtrig_word_t d);
    @(posedge mclk_i);
    #1;
    exec_vld_o = (k == 2'h0);
    ld_vld_o = (k == 2'h1);
    st_vld_o = (k == 2'h2);
    ebreak_o = (k == 2'h3);
    exec_addr_o = (k == 2'h0) ? a : ~a;
    ld_addr_o = (k == 2'h1) ? a : ~a;
    st_addr_o = (k == 2'h2) ? a : ~a;
    st_data_o = d;
    @(posedge mclk_i);
    #1;
    {exec_vld_o, ld_vld_o, st_vld_o, ebreak_o} = 4'h0;
    exec_addr_o = ~a;
    ld_addr_o = ~a;
    st_addr_o = ~a;
    st_data_o = ~d;
  endtask : ev

  task automatic mode(input logic dbg, input logic m);
    @(posedge mclk_i);
    #1;
    dbg_mode_o = dbg;
    mmode_o = m;
  endtask : mode
endmodule : dtrig_hart_model
`default_nettype wire

// ### bench/tb_debug_trigger_and_halt_control.sv
// self-checking bench of the trigger and debug csr block
// assumes: dtrig_hart_model plays the hart and debugger
`timescale 1ns/10ps
`default_nettype none
`include "dtrig_defines.svh"
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module tb_debug_trigger_and_halt_control;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic csr_req, csr_we, csr_ack, csr_ill, dbg_mode, mmode, exec_vld, ld_vld, st_vld, ebreak;
  logic trig_bkpt, trig_dbg, eb_dbg, eb_trap, step_ie, il_v, ak_v;
  logic [11:0] csr_addr;
  dtrig_pkg::dtrig_word_t csr_wdata, csr_rdata, exec_addr, ld_addr, st_addr, st_data, rd_v;
  int err_total = 0;
  int samples_checked = 0;

  always #2 mclk_i = ~mclk_i;

  dtrig_top dut_u (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .csr_req_i(csr_req), .csr_we_i(csr_we),
    .csr_addr_i(csr_addr), .csr_wdata_i(csr_wdata), .csr_ack_o(csr_ack), .csr_illegal_o(csr_ill),
    .csr_rdata_o(csr_rdata), .dbg_mode_i(dbg_mode), .mmode_i(mmode), .exec_vld_i(exec_vld),
    .exec_addr_i(exec_addr), .ld_vld_i(ld_vld), .ld_addr_i(ld_addr), .st_vld_i(st_vld),
    .st_addr_i(st_addr), .st_data_i(st_data), .ebreak_i(ebreak), .trig_bkpt_o(trig_bkpt),
    .trig_dbg_o(trig_dbg), .ebreak_dbg_o(eb_dbg), .ebreak_trap_o(eb_trap), .step_ie_o(step_ie)
  );

  dtrig_hart_model hart (
    .mclk_i(mclk_i), .csr_req_o(csr_req), .csr_we_o(csr_we), .csr_addr_o(csr_addr),
    .csr_wdata_o(csr_wdata), .csr_ack_i(csr_ack), .csr_illegal_i(csr_ill), .csr_rdata_i(csr_rdata),
    .dbg_mode_o(dbg_mode), .mmode_o(mmode), .exec_vld_o(exec_vld), .ld_vld_o(ld_vld),
    .st_vld_o(st_vld), .ebreak_o(ebreak), .exec_addr_o(exec_addr), .ld_addr_o(ld_addr),
    .st_addr_o(st_addr), .st_data_o(st_data)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic acc(input logic we, input logic [11:0] a, input dtrig_pkg::dtrig_word_t d);
    hart.csr(we, a, d, rd_v, il_v, ak_v);
    `CHK(ak_v, 1'b1)
  endtask : acc

  task automatic ev_chk(input logic [1:0] k, input dtrig_pkg::dtrig_word_t a,
                        input dtrig_pkg::dtrig_word_t d, input logic eb, input logic ed);
    hart.ev(k, a, d);
    `CHK(trig_bkpt, eb)
    `CHK(trig_dbg, ed)
  endtask : ev_chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    acc(1'b0, `DTRIG_CSR_CMP, 32'h0);
    `CHK(rd_v, 32'h0000_0000)
    acc(1'b0, `DTRIG_CSR_CTRL, 32'h0);
    `CHK(rd_v, 32'h0000_0000)
    acc(1'b0, `DTRIG_CSR_DBGCS, 32'h0);
    `CHK(rd_v, 32'h4000_0000)
    `CHK(step_ie, 1'b0)
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    acc(1'b1, `DTRIG_CSR_CMP, 32'hA5A5_5A5A);
    `CHK(rd_v, 32'h0000_0000)
    acc(1'b0, `DTRIG_CSR_CMP, 32'h0);
    `CHK(rd_v, 32'hA5A5_5A5A)
    acc(1'b1, `DTRIG_CSR_CTRL, 32'hFFFF_FFFF);
    acc(1'b0, `DTRIG_CSR_CTRL, 32'h0);
    `CHK(rd_v, 32'h0018_0047)
    acc(1'b1, `DTRIG_CSR_CTRL, 32'h0000_1080);
    acc(1'b1, `DTRIG_CSR_CTRL, 32'h0000_2100);
    acc(1'b0, `DTRIG_CSR_CTRL, 32'h0);
    `CHK(rd_v, 32'h0000_1080)
    // written only while halted
    acc(1'b1, `DTRIG_CSR_DBGCS, 32'hFFFF_FFFF);
    acc(1'b0, `DTRIG_CSR_DBGCS, 32'h0);
    `CHK(rd_v, 32'h4000_8800)
    `CHK(step_ie, 1'b1)
    acc(1'b0, 12'h7A3, 32'h0);
    `CHK(il_v, 1'b1)
    $display("test registers done");
  endtask : t_regs

  task automatic t_illegal();
    hart.mode(1'b0, 1'b1);
    acc(1'b1, `DTRIG_CSR_DBGCS, 32'h0000_0000);
    `CHK(il_v, 1'b1)
    `CHK(rd_v, 32'h0000_0000)
    hart.mode(1'b1, 1'b1);
    acc(1'b0, `DTRIG_CSR_DBGCS, 32'h0);
    `CHK(rd_v, 32'h4000_8800)
    `CHK(il_v, 1'b0)
    $display("test illegal done");
  endtask : t_illegal

  task automatic t_match();
    acc(1'b1, `DTRIG_CSR_CMP, 32'h0000_1000);
    acc(1'b1, `DTRIG_CSR_CTRL, 32'h0000_0044);
    hart.mode(1'b0, 1'b1);
    ev_chk(2'h0, 32'h0000_1000, 32'h0, 1'b1, 1'b0);
    acc(1'b0, `DTRIG_CSR_CTRL, 32'h0);
    `CHK(rd_v, 32'h0010_0044)
    ev_chk(2'h0, 32'h0000_1001, 32'h0, 1'b0, 1'b0);
    for (int e = 0; e < 3; e++) begin
      for (int k = 0; k < 3; k++) begin
        acc(1'b1, `DTRIG_CSR_CTRL, 32'h0000_0040 | (32'h1 << e));
        ev_chk(k[1:0], 32'h0000_1000, 32'h0, (e == 0 && k == 1) || (e == 1 && k == 2) || (e == 2 && k == 0),
               1'b0);
      end
    end
    acc(1'b1, `DTRIG_CSR_CTRL, 32'h0008_0047);
    ev_chk(2'h2, 32'h0000_1000, 32'h0, 1'b0, 1'b0);
    ev_chk(2'h2, 32'h0000_2000, 32'h0000_1000, 1'b1, 1'b0);
    ev_chk(2'h1, 32'h0000_1000, 32'h0000_1000, 1'b0, 1'b0);
    ev_chk(2'h0, 32'h0000_1000, 32'h0000_1000, 1'b0, 1'b0);
    acc(1'b1, `DTRIG_CSR_CMP, 32'h0000_10FF);
    acc(1'b1, `DTRIG_CSR_CTRL, 32'h0000_10C4);
    ev_chk(2'h0, 32'h0000_1100, 32'h0, 1'b0, 1'b1);
    ev_chk(2'h0, 32'h0000_1300, 32'h0, 1'b0, 1'b0);
    hart.mode(1'b0, 1'b0);
    ev_chk(2'h0, 32'h0000_1100, 32'h0, 1'b0, 1'b0);
    hart.mode(1'b0, 1'b1);
    acc(1'b1, `DTRIG_CSR_CTRL, 32'h0000_1084);
    ev_chk(2'h0, 32'h0000_1100, 32'h0, 1'b0, 1'b0);
    // lowest zero at bit 0: a load differing only there still matches
    acc(1'b1, `DTRIG_CSR_CMP, 32'h0000_1000);
    acc(1'b1, `DTRIG_CSR_CTRL, 32'h0000_00C1);
    ev_chk(2'h1, 32'h0000_1001, 32'h0, 1'b1, 1'b0);
    $display("test match done");
  endtask : t_match

  task automatic t_ebreak();
    // ebreak enable was left set by the register test
    hart.mode(1'b1, 1'b1);
    acc(1'b1, `DTRIG_CSR_DBGCS, 32'h0000_0000);
    `CHK(step_ie, 1'b0)
    hart.mode(1'b0, 1'b1);
    ev_chk(2'h3, 32'h0, 32'h0, 1'b0, 1'b0);
    `CHK(eb_trap, 1'b1)
    `CHK(eb_dbg, 1'b0)
    hart.mode(1'b1, 1'b1);
    acc(1'b1, `DTRIG_CSR_DBGCS, 32'h0000_8800);
    `CHK(step_ie, 1'b1)
    hart.mode(1'b0, 1'b1);
    ev_chk(2'h3, 32'h0, 32'h0, 1'b0, 1'b0);
    `CHK(eb_dbg, 1'b1)
    `CHK(eb_trap, 1'b0)
    $display("test ebreak done");
  endtask : t_ebreak

  initial begin
    repeat (10) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_regs();
    t_illegal();
    t_match();
    t_ebreak();
    tally_and_finish();
  end

  // hang guard
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule : tb_debug_trigger_and_halt_control
`default_nettype wire
